// ---- dv/far_end_model.sv ----
`timescale 1ns/1ps
module far_end_model (
  output logic o_clk
);
  // Partner in the opposite role supplies a 50 MHz clock
  // Left free running so an undriven pin never shows a frozen level
  initial o_clk = 1'b0;
  always #10 o_clk = ~o_clk;
endmodule

// ---- dv/mac_port_cfg_checker.sv ----
`timescale 1ns/1ps
module mac_port_cfg_checker (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_link_clk,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic o_receive_clock_pin_oe,
  input wire mac_port_cfg_pkg::iface_type o_interface_type,
  input wire logic o_mac_role,
  input wire mac_port_cfg_pkg::speed_type o_speed
);
  import mac_port_cfg_pkg::*;
  logic ra;
  logic rb;
  logic wb;
  assign ra = i_rd && i_addr == ctrl_a_offset;
  assign rb = i_rd && i_addr == ctrl_b_offset;
  assign wb = i_wr && i_addr == ctrl_b_offset;
  a_rdata_idle_zero: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !$past(i_rd) |-> o_rdata == 8'h00) else $error("read data not idle");
  a_ctrl_a_reset: assert property (@(posedge i_core_clk) disable iff (i_srst)
    $past(i_srst) && ra |=> o_rdata == ctrl_a_reset) else $error("ctrl_a reset value");
  a_ctrl_a_write: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_wr && i_addr == ctrl_a_offset ##1 ra |=> o_rdata == ($past(i_wdata, 2) & ctrl_a_write_mask))
    else $error("ctrl_a readback");
  a_ctrl_b_write: assert property (@(posedge i_core_clk) disable iff (i_srst)
    wb && i_wdata[1:0] != 2'h2 ##1 rb |=> o_rdata == $past(i_wdata, 2))
    else $error("ctrl_b readback");
  a_type_reserved_kept: assert property (@(posedge i_core_clk) disable iff (i_srst)
    wb && i_wdata[1:0] == 2'h2 ##1 rb |=> o_rdata[1:0] != 2'h2) else $error("reserved type stored");
  a_type_never_reserved: assert property (@(posedge i_link_clk) disable iff (i_srst)
    o_interface_type != iface_reserved) else $error("reserved type applied");
  a_phy_drives_pin: assert property (@(posedge i_link_clk) disable iff (i_srst)
    (!o_mac_role && o_interface_type != iface_rgmii) [*4] |-> o_receive_clock_pin_oe)
    else $error("clock pin not driven");
  a_mac_pin_quiet: assert property (@(posedge i_link_clk) disable iff (i_srst)
    (o_mac_role || o_interface_type == iface_rgmii) [*4] |-> !o_receive_clock_pin_oe)
    else $error("clock pin driven");
  a_speed_code_legal: assert property (@(posedge i_link_clk) disable iff (i_srst)
    o_speed != 2'h3) else $error("illegal speed code");
  c_gigabit: cover property (@(posedge i_link_clk) o_speed == speed_1000);
  c_pin_driven: cover property (@(posedge i_link_clk) o_receive_clock_pin_oe);
  c_reserved_write: cover property (@(posedge i_core_clk) wb && i_wdata[1:0] == 2'h2);
endmodule
bind mac_port_interface_config mac_port_cfg_checker chk (.i_core_clk(i_core_clk),
  .i_srst(i_srst), .i_link_clk(i_link_clk), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_receive_clock_pin_oe(o_receive_clock_pin_oe),
  .o_interface_type(o_interface_type), .o_mac_role(o_mac_role), .o_speed(o_speed));

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import mac_port_cfg_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_link_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic spd = 1'b1;
  logic role = 1'b0;
  logic [1:0] ty = 2'h0;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] o_rdata;
  logic p_out, p_oe, far_clk, dup, txf, rxf, mac, rxd, txd;
  logic [1:0] exp_ty;
  iface_type o_type;
  speed_type o_speed;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  initial forever #12.5 i_core_clk = ~i_core_clk;
  initial begin
    #7;
    forever #24 i_link_clk = ~i_link_clk;
  end
  far_end_model far (.o_clk(far_clk));
  // Pin level: device wins while its enable is high
  mac_port_interface_config uut (.i_core_clk(i_core_clk), .i_srst(i_srst),
    .i_link_clk(i_link_clk), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_speed_strap_pin(spd), .i_role_strap_pin(role),
    .i_type_strap_pins(ty), .i_receive_clock_pin(p_oe ? p_out : far_clk),
    .o_receive_clock_pin(p_out), .o_receive_clock_pin_oe(p_oe), .o_interface_type(o_type),
    .o_mac_role(mac), .o_speed(o_speed), .o_full_duplex(dup), .o_tx_flow_enable(txf),
    .o_rx_flow_enable(rxf), .o_receive_clock_delay_enable(rxd),
    .o_transmit_clock_delay_enable(txd));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd_chk(input string n, input logic [15:0] a, input logic [7:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    chk(n, e, o_rdata);
    @(posedge i_core_clk);
  endtask
  // Reset is held long enough for the slower link domain to see it too
  task automatic do_reset(input logic s, input logic r, input logic [1:0] t);
    spd <= s;
    role <= r;
    ty <= t;
    i_srst <= 1'b1;
    repeat (8) @(posedge i_core_clk);
    i_srst <= 1'b0;
  endtask
  task automatic settle;
    repeat (10) @(posedge i_core_clk);
  endtask
  task automatic t_reset;
    do_reset(1'b0, 1'b1, 2'h1);
    rd_chk("ctrl_a", 16'h3300, 8'h50);
    rd_chk("ctrl_b", 16'h3301, 8'h0d);
    settle();
    chk("speed", 8'h2, 8'(o_speed));
    chk("duplex", 8'h1, 8'(dup));
    chk("oe", 8'h0, 8'(p_oe));
    do_reset(1'b1, 1'b0, 2'h3);
    rd_chk("ctrl_b", 16'h3301, 8'h4b);
    settle();
    chk("speed", 8'h1, 8'(o_speed));
    $display("test reset done");
  endtask
  task automatic t_ctrl_a;
    wr_reg(16'h3300, 8'hff);
    rd_chk("ctrl_a", 16'h3300, 8'h7f);
    wr_reg(16'h3300, 8'h28);
    settle();
    chk("flags", 8'h07, {4'h0, dup, txf, rxf, 1'b1});
    chk("speed", 8'h0, 8'(o_speed));
    wr_reg(16'h3301, 8'h0b);
    settle();
    chk("speed", 8'h2, 8'(o_speed));
    wr_reg(16'h3303, 8'hff);
    rd_chk("unmapped", 16'h3303, 8'h00);
    $display("test ctrl_a done");
  endtask
  task automatic t_types;
    exp_ty = 2'h3;
    for (int k = 0; k < 8; k++) begin
      wr_reg(16'h3301, 8'h10 | 8'(k));
      if (k[1:0] != 2'h2) begin
        exp_ty = 2'(k);
      end
      rd_chk("ctrl_b", 16'h3301, {5'h02, k[2], exp_ty});
      settle();
      chk("type", 8'(exp_ty), 8'(o_type));
      chk("oe", 8'(!k[2] && exp_ty != 2'h3), 8'(p_oe));
      chk("delays", 8'h2, {6'h0, rxd, txd});
      chk("role", 8'(k[2]), 8'(mac));
      rd_chk("status", 16'h3302, {6'h0, !k[2] && exp_ty != 2'h3, 1'b1});
    end
    $display("test types done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    t_reset();
    t_ctrl_a();
    t_types();
    tally_and_finish();
  end
endmodule

// ---- hdl/mac_port_cfg_pkg.sv ----
package mac_port_cfg_pkg;

  // Register port geometry
  localparam int unsigned addr_width = 16;
  localparam int unsigned data_width = 8;

  // Register offsets
  localparam logic [15:0] ctrl_a_offset = 16'h3300;
  localparam logic [15:0] ctrl_b_offset = 16'h3301;
  localparam logic [15:0] status_offset = 16'h3302;

  // First control register fields
  localparam int unsigned duplex_bit = 6;
  localparam int unsigned tx_flow_bit = 5;
  localparam int unsigned speed_100_bit = 4;
  localparam int unsigned rx_flow_bit = 3;
  localparam logic [7:0] ctrl_a_reset = 8'h50;
  localparam logic [7:0] ctrl_a_write_mask = 8'h7f;

  // Second control register fields
  localparam int unsigned speed_not_1000_bit = 6;
  localparam int unsigned rx_delay_bit = 4;
  localparam int unsigned tx_delay_bit = 3;
  localparam int unsigned role_bit = 2;
  localparam int unsigned type_lsb = 0;
  localparam logic [7:0] ctrl_b_reset = 8'h08;
  localparam logic [7:0] ctrl_b_strap_mask = 8'h47;

  // Status register fields
  localparam int unsigned clk_activity_bit = 0;
  localparam int unsigned pin_driven_bit = 1;

  // Width of the configuration word carried to the link domain
  localparam int unsigned cfg_width = 10;

  typedef enum logic [1:0] {
    iface_mii = 2'h0,
    iface_rmii = 2'h1,
    iface_reserved = 2'h2,
    iface_rgmii = 2'h3
  } iface_type;

  typedef enum logic [1:0] {
    speed_10 = 2'h0,
    speed_100 = 2'h1,
    speed_1000 = 2'h2
  } speed_type;

endpackage

// ---- hdl/mac_port_interface_config.sv ----
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module mac_port_interface_config (
  // Core clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Link clock
  input wire logic i_link_clk,
  // Register port
  input wire logic [mac_port_cfg_pkg::addr_width-1:0] i_addr,
  input wire logic [mac_port_cfg_pkg::data_width-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [mac_port_cfg_pkg::data_width-1:0] o_rdata,
  // Configuration straps
  input wire logic i_speed_strap_pin,
  input wire logic i_role_strap_pin,
  input wire logic [1:0] i_type_strap_pins,
  // Receive clock pin
  input wire logic i_receive_clock_pin,
  output logic o_receive_clock_pin,
  output logic o_receive_clock_pin_oe,
  // Applied port configuration, link domain
  output mac_port_cfg_pkg::iface_type o_interface_type,
  output logic o_mac_role,
  output mac_port_cfg_pkg::speed_type o_speed,
  output logic o_full_duplex,
  output logic o_tx_flow_enable,
  output logic o_rx_flow_enable,
  output logic o_receive_clock_delay_enable,
  output logic o_transmit_clock_delay_enable
);
  import mac_port_cfg_pkg::*;

  // Strap and pin synchronisers, core domain
  logic [3:0] strap_meta;
  logic [3:0] strap_sync;
  logic pin_meta;
  logic pin_sync;
  logic pin_prev;

  always_ff @(posedge i_core_clk) begin
    strap_meta <= {i_speed_strap_pin, i_role_strap_pin, i_type_strap_pins};
    strap_sync <= strap_meta;
    pin_meta <= i_receive_clock_pin;
    pin_sync <= pin_meta;
    pin_prev <= pin_sync;
  end

  // Register file
  logic [7:0] ctrl_a;
  logic [7:0] ctrl_b;
  logic activity;
  logic [7:0] rdata;
  logic [7:0] next_ctrl_a;
  logic [7:0] next_ctrl_b;
  logic next_activity;
  logic [7:0] next_rdata;
  logic [7:0] strap_fields;
  logic pin_edge;
  logic pin_driven;

  always_comb begin
    strap_fields = ctrl_b_reset;
    strap_fields[speed_not_1000_bit] = strap_sync[3];
    strap_fields[role_bit] = strap_sync[2];
    strap_fields[type_lsb +: 2] = strap_sync[1:0];
    pin_edge = pin_sync ^ pin_prev;
    pin_driven = !ctrl_b[role_bit] && (ctrl_b[type_lsb +: 2] == iface_mii
                 || ctrl_b[type_lsb +: 2] == iface_rmii);
    next_ctrl_a = ctrl_a;
    next_ctrl_b = ctrl_b;
    next_activity = activity;
    next_rdata = 8'h00;
    if (i_srst) begin
      next_ctrl_a = ctrl_a_reset;
      // Straps load while reset is held; the synchroniser settles in two edges
      next_ctrl_b = (ctrl_b_reset & ~ctrl_b_strap_mask) | (strap_fields & ctrl_b_strap_mask);
      next_activity = 1'b0;
    end else begin
      if (i_wr && i_addr == ctrl_a_offset) begin
        next_ctrl_a = i_wdata & ctrl_a_write_mask;
      end
      if (i_wr && i_addr == ctrl_b_offset) begin
        next_ctrl_b = i_wdata;
        // The reserved type code is refused on writes; a reserved strap value still loads while reset is held
        if (i_wdata[type_lsb +: 2] == iface_reserved) begin
          next_ctrl_b[type_lsb +: 2] = ctrl_b[type_lsb +: 2];
        end
      end
      if (i_rd) begin
        case (i_addr)
          ctrl_a_offset: begin
            next_rdata = ctrl_a;
          end
          ctrl_b_offset: begin
            next_rdata = ctrl_b;
          end
          status_offset: begin
            next_rdata[clk_activity_bit] = activity;
            next_rdata[pin_driven_bit] = pin_driven;
          end
          default: begin
            next_rdata = 8'h00;
          end
        endcase
      end
      // Activity is sticky and cleared by reading it; a new edge wins
      if (i_rd && i_addr == status_offset) begin
        next_activity = 1'b0;
      end
      if (pin_edge) begin
        next_activity = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    ctrl_a <= next_ctrl_a;
    ctrl_b <= next_ctrl_b;
    activity <= next_activity;
    rdata <= next_rdata;
  end

  assign o_rdata = rdata;

  // Configuration word, core domain
  logic [cfg_width-1:0] cfg_core;

  assign cfg_core = {ctrl_a[duplex_bit], ctrl_a[tx_flow_bit], ctrl_a[rx_flow_bit],
                     ctrl_a[speed_100_bit], ctrl_b[speed_not_1000_bit],
                     ctrl_b[rx_delay_bit], ctrl_b[tx_delay_bit], ctrl_b[role_bit],
                     ctrl_b[type_lsb +: 2]};

  // Link domain; fields are quasi-static, so per-bit two-flop crossing is
  // enough, at the cost of a one-cycle skew between bits after a write
  logic [cfg_width-1:0] cfg_meta;
  logic [cfg_width-1:0] cfg_link;
  logic clk_out;
  logic clk_oe;
  iface_type iface;
  speed_type speed;
  logic full_duplex;
  logic tx_flow;
  logic rx_flow;
  logic rx_delay;
  logic tx_delay;
  logic mac_role;
  logic next_clk_out;
  logic next_clk_oe;
  iface_type next_iface;
  speed_type next_speed;
  logic next_full_duplex;
  logic next_tx_flow;
  logic next_rx_flow;
  logic next_rx_delay;
  logic next_tx_delay;
  logic next_mac_role;
  // Reset is asynchronous to this domain, so it passes two flops first
  logic rst_meta;
  logic rst_link;

  always_comb begin
    next_full_duplex = cfg_link[9];
    next_tx_flow = cfg_link[8];
    next_rx_flow = cfg_link[7];
    if (!cfg_link[5]) begin
      next_speed = speed_1000;
    end else if (cfg_link[6]) begin
      next_speed = speed_100;
    end else begin
      next_speed = speed_10;
    end
    next_rx_delay = cfg_link[4];
    next_tx_delay = cfg_link[3];
    next_mac_role = cfg_link[2];
    next_iface = iface_type'(cfg_link[1:0]);
    // Role 0 in MII or RMII drives the receive clock pin; RGMII never does
    next_clk_oe = !cfg_link[2] && (cfg_link[1:0] == iface_mii
                  || cfg_link[1:0] == iface_rmii);
    // Divide the link clock by two to make the driven reference clock
    next_clk_out = next_clk_oe ? !clk_out : 1'b0;
    if (rst_link) begin
      next_clk_oe = 1'b0;
      next_clk_out = 1'b0;
    end
  end

  always_ff @(posedge i_link_clk) begin
    rst_meta <= i_srst;
    rst_link <= rst_meta;
    cfg_meta <= cfg_core;
    cfg_link <= cfg_meta;
    clk_out <= next_clk_out;
    clk_oe <= next_clk_oe;
    iface <= next_iface;
    speed <= next_speed;
    full_duplex <= next_full_duplex;
    tx_flow <= next_tx_flow;
    rx_flow <= next_rx_flow;
    rx_delay <= next_rx_delay;
    tx_delay <= next_tx_delay;
    mac_role <= next_mac_role;
  end

  assign o_receive_clock_pin = clk_out;
  assign o_receive_clock_pin_oe = clk_oe;
  assign o_interface_type = iface;
  assign o_mac_role = mac_role;
  assign o_speed = speed;
  assign o_full_duplex = full_duplex;
  assign o_tx_flow_enable = tx_flow;
  assign o_rx_flow_enable = rx_flow;
  assign o_receive_clock_delay_enable = rx_delay;
  assign o_transmit_clock_delay_enable = tx_delay;

endmodule
